// file: hdl/bpc_pkg.sv
// bpc_pkg: constants, codes and carrier structs of the buck supervisory block.
// assumes a single 25 MHz clock; all pins arrive asynchronous to it.
package bpc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SS_TIME_US = 2800;
    localparam int SS_CYCLES = SS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int HICCUP_OFF_COUNT = 16384;
    localparam logic [8:0] HIC_TERMINAL = 9'h1ff;
    localparam logic [4:0] CLAMP_EVENTS = 5'h10;
    localparam logic [1:0] CLEAN_LAST = 2'h3;
    localparam logic [1:0] LOCK_EDGES = 2'h2;
    localparam logic [7:0] SYNC_IDLE_CLKS = 8'h40;
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [15:0] CTRL_PERIOD_RST = 16'h003e;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CFG_SOLO = 3'b000,
        CFG_SOLO_SPREAD = 3'b001,
        CFG_PRI = 3'b010,
        CFG_PRI_SPREAD = 3'b011,
        CFG_SEC = 3'b100
    } bpc_cfg_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b10,
        ST_HICCUP = 2'b11
    } bpc_fsm_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] config_code;
        logic comp_strap;
        logic fb_tied_high;
        logic mode_sync_in;
        logic ton_short;
        logic pwm_on;
        logic fb_above;
        logic cl_trip;
        logic en;
    } bpc_pins_t;

    typedef struct packed {
        logic hs_gate;
        logic ls_gate;
        logic ss_force_low;
        logic ss_clamp_en;
        logic erramp_off;
        logic internal_comp;
        logic spread_en;
        logic pulse_skip;
    } bpc_drive_t;

    typedef struct packed {
        logic [11:0] reserved;
        logic armed;
        logic [8:0] hic_cnt;
        logic clamp_en;
        logic skip;
        logic locked;
        logic light;
        logic comp_int;
        logic [2:0] cfg;
        logic [1:0] fsm;
    } bpc_status_t;

endpackage

// file: hdl/bpc_sync2.sv
// bpc_sync2: two-flop synchroniser for a group of asynchronous pins.
// assumes inputs are levels that hold for several clk periods.
`timescale 1ns/1ps
module bpc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } bpc_sync_state_t;

    bpc_sync_state_t s_q;
    bpc_sync_state_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    // constant reset values only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// file: hdl/bpc_top.sv
// bpc_top: supervisory logic of a synchronous buck converter: current limit,
// soft-start clamp, hiccup protection, pulse skipping, strap latching and
// dual-phase sync, with an apb slave for period control and status.
// assumes analog comparators and strap decoding arrive as logic pins.
//
// Overview of operation
// - current limit ends high-side pulse immediately
// - soft-start clamp only after sixteen overcurrent events
// - after soft-start, count limit incidents to 512
// - four clean cycles in row clear counter
// - terminal count with feedback high restarts counter
// - terminal count, feedback low: soft-start low, drivers off
// - off-time reaches 16384: restart soft-start
// - hiccup inactive in soft-start until feedback rises
// - too-short on-time demand makes device skip pulses
// - internal compensation only when strap detected
// - compensation choice held until power recycle
// - config strap latched at start, resampled on enable
// - decode five strap configuration codes
// - spread spectrum on ignores external clock
// - secondary disables error amp, internal comp unsupported
// - primary drives sync clock half period shifted
// - secondary switches from primary sync clock
// - dual-phase mode set by primary mode, secondary feedback
// - lock to newly appearing sync after two cycles
// - skipping primary in light-load mode stops sync
// - secondary enable cycle forces soft-start restart
// - mode pin high light-load, low or clocked forced
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module bpc_top #(
    parameter int SS_CYCLES = bpc_pkg::SS_CYCLES,
    parameter int HICCUP_OFF = bpc_pkg::HICCUP_OFF_COUNT
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire bpc_pkg::bpc_pins_t pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output bpc_pkg::bpc_drive_t drive,
    output logic good_flag_sync_out,
    output logic good_flag_sync_oe
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        bpc_pkg::bpc_fsm_t fsm;
        bpc_pkg::bpc_cfg_t cfg;
        logic comp_int;
        logic comp_valid;
        logic [1:0] settle;
        logic [15:0] period;
        logic [15:0] osc;
        logic cl_seen;
        logic [8:0] hic_cnt;
        logic [1:0] clean;
        logic [4:0] clamp_cnt;
        logic armed;
        logic [16:0] ss_cnt;
        logic [14:0] off_cnt;
        logic en_prev;
        logic sync_prev;
        logic [1:0] sync_edges;
        logic locked;
        logic [7:0] idle;
        logic skip;
        logic hs;
        logic ls;
        logic sync_out;
        logic sync_oe;
        logic [31:0] prdata;
        logic pslverr;
    } bpc_state_t;

    bpc_state_t s_q;
    bpc_state_t s_d;
    bpc_pkg::bpc_pins_t pin_s;
    bpc_pkg::bpc_status_t status;

    logic is_sec;
    logic is_pri;
    logic spread;
    logic sync_rise;
    logic clocked;
    logic light;
    logic use_ext;
    logic tick;
    logic active;
    logic terminal;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    bpc_sync2 #(
        .W($bits(bpc_pkg::bpc_pins_t))
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(pins),
        .sync_out(pin_s)
    );

    // ----------------------------------------------------------------
    // decode and derived conditions
    // ----------------------------------------------------------------
    // five strap codes; anything else behaves as plain standalone
    always_comb begin
        is_sec = (s_q.cfg == bpc_pkg::CFG_SEC);
        is_pri = (s_q.cfg == bpc_pkg::CFG_PRI) || (s_q.cfg == bpc_pkg::CFG_PRI_SPREAD);
        spread = (s_q.cfg == bpc_pkg::CFG_SOLO_SPREAD) || (s_q.cfg == bpc_pkg::CFG_PRI_SPREAD);
        sync_rise = pin_s.mode_sync_in && !s_q.sync_prev;
        clocked = (s_q.idle < bpc_pkg::SYNC_IDLE_CLKS);
        // a steady high pin means light load; a clock means forced pwm
        if (is_sec) begin
            light = pin_s.fb_tied_high;
        end else begin
            light = pin_s.mode_sync_in && !clocked;
        end
        // spread spectrum keeps the device on its own oscillator
        use_ext = s_q.locked && (is_sec || !spread);
        if (use_ext) begin
            tick = sync_rise;
        end else begin
            tick = (s_q.osc >= s_q.period);
        end
        active = (s_q.fsm == bpc_pkg::ST_SOFT) || (s_q.fsm == bpc_pkg::ST_RUN);
        terminal = (s_q.hic_cnt == bpc_pkg::HIC_TERMINAL);
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.en_prev = pin_s.en;
        s_d.sync_prev = pin_s.mode_sync_in;

        // compensation strap is caught once per power-up, never again;
        // waits for the synchroniser, which reads zero straight after reset
        if (!s_q.comp_valid) begin
            if (s_q.settle == bpc_pkg::SYNC_SETTLE) begin
                s_d.comp_valid = 1'b1;
                s_d.comp_int = pin_s.comp_strap;
            end else begin
                s_d.settle = s_q.settle + 2'h1;
            end
        end

        // sync activity: idle counter and two-edge lock
        if (sync_rise) begin
            s_d.idle = '0;
            if (!s_q.locked) begin
                s_d.sync_edges = s_q.sync_edges + 2'h1;
                if (s_q.sync_edges + 2'h1 >= bpc_pkg::LOCK_EDGES) begin
                    s_d.locked = 1'b1;
                end
            end
        end else if (clocked) begin
            s_d.idle = s_q.idle + 8'h01;
        end
        if (!clocked) begin
            s_d.locked = 1'b0;
            s_d.sync_edges = '0;
        end

        // oscillator; an external edge realigns it
        if (tick) begin
            s_d.osc = '0;
        end else if (s_q.osc != 16'hffff) begin
            s_d.osc = s_q.osc + 16'h0001;
        end

        // current-limit memory within the cycle
        if (pin_s.cl_trip) begin
            s_d.cl_seen = 1'b1;
        end

        // high-side pulse: started at tick, cut by limit or pwm latch
        if (tick) begin
            s_d.skip = pin_s.ton_short;
            s_d.hs = active && !pin_s.ton_short;
            s_d.cl_seen = pin_s.cl_trip;
        end else if (pin_s.cl_trip || !pin_s.pwm_on) begin
            s_d.hs = 1'b0;
        end
        s_d.ls = active && !s_d.hs;

        // per-switching-cycle event counters
        if (tick && active) begin
            if (s_q.cl_seen) begin
                s_d.clean = '0;
                if (s_q.clamp_cnt != bpc_pkg::CLAMP_EVENTS) begin
                    s_d.clamp_cnt = s_q.clamp_cnt + 5'h01;
                end
                // hiccup counting only once armed after soft-start
                if (s_q.fsm == bpc_pkg::ST_RUN && s_q.armed) begin
                    if (terminal) begin
                        if (pin_s.fb_above) begin
                            s_d.hic_cnt = '0;
                        end else begin
                            s_d.fsm = bpc_pkg::ST_HICCUP;
                            s_d.hic_cnt = '0;
                            s_d.off_cnt = '0;
                            s_d.hs = 1'b0;
                            s_d.ls = 1'b0;
                        end
                    end else begin
                        s_d.hic_cnt = s_q.hic_cnt + 9'h001;
                    end
                end
            end else begin
                s_d.clean = s_q.clean + 2'h1;
                if (s_q.clean == bpc_pkg::CLEAN_LAST) begin
                    s_d.clean = '0;
                    s_d.hic_cnt = '0;
                    s_d.clamp_cnt = '0;
                end
            end
        end

        // soft-start, arming and hiccup off-time
        unique case (s_q.fsm)
            bpc_pkg::ST_OFF: begin
                s_d.hs = 1'b0;
                s_d.ls = 1'b0;
            end
            bpc_pkg::ST_SOFT: begin
                s_d.armed = 1'b0;
                if (s_q.ss_cnt >= 17'(SS_CYCLES - 1)) begin
                    s_d.fsm = bpc_pkg::ST_RUN;
                end else begin
                    s_d.ss_cnt = s_q.ss_cnt + 17'h00001;
                end
            end
            bpc_pkg::ST_RUN: begin
                if (pin_s.fb_above) begin
                    s_d.armed = 1'b1;
                end
            end
            bpc_pkg::ST_HICCUP: begin
                s_d.hs = 1'b0;
                s_d.ls = 1'b0;
                if (tick) begin
                    if (s_q.off_cnt >= 15'(HICCUP_OFF - 1)) begin
                        s_d.fsm = bpc_pkg::ST_SOFT;
                        s_d.ss_cnt = '0;
                        s_d.clamp_cnt = '0;
                    end else begin
                        s_d.off_cnt = s_q.off_cnt + 15'h0001;
                    end
                end
            end
        endcase

        // enable: rising edge latches config and starts soft-start;
        // low clears the fsm, counters, arming and gates so a shed secondary restarts cleanly
        if (!pin_s.en) begin
            s_d.fsm = bpc_pkg::ST_OFF;
            s_d.hic_cnt = '0;
            s_d.clean = '0;
            s_d.clamp_cnt = '0;
            s_d.ss_cnt = '0;
            s_d.off_cnt = '0;
            s_d.armed = 1'b0;
            s_d.hs = 1'b0;
            s_d.ls = 1'b0;
        end else if (!s_q.en_prev) begin
            s_d.fsm = bpc_pkg::ST_SOFT;
            s_d.cfg = bpc_pkg::bpc_cfg_t'(pin_s.config_code);
            if (pin_s.config_code > bpc_pkg::CFG_SEC) begin
                s_d.cfg = bpc_pkg::CFG_SOLO;
            end
        end

        // primary sync output lags by half a period, stops while skipping in light load;
        // enable follows the config being latched, never a cycle behind it
        s_d.sync_oe = (s_d.cfg == bpc_pkg::CFG_PRI) || (s_d.cfg == bpc_pkg::CFG_PRI_SPREAD);
        s_d.sync_out = s_d.sync_oe && active
            && (s_q.osc >= (s_q.period >> 1))
            && !(light && s_q.skip);

        // apb: read data prepared in the setup phase, zero wait states
        if (psel && !penable) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            if (paddr == bpc_pkg::REG_CTRL) begin
                s_d.prdata = {16'h0000, s_q.period};
            end else if (paddr == bpc_pkg::REG_STATUS) begin
                s_d.prdata = status;
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        if (psel && penable && pwrite && paddr == bpc_pkg::REG_CTRL) begin
            s_d.period = pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    always_comb begin
        status = '0;
        status.fsm = s_q.fsm;
        status.cfg = s_q.cfg;
        status.comp_int = s_q.comp_int;
        status.light = light;
        status.locked = s_q.locked;
        status.skip = s_q.skip;
        status.clamp_en = (s_q.clamp_cnt == bpc_pkg::CLAMP_EVENTS);
        status.hic_cnt = s_q.hic_cnt;
        status.armed = s_q.armed;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // power-on reset doubles as the bias-rail recycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.period <= bpc_pkg::CTRL_PERIOD_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // soft-start held low while off or in hiccup
    always_comb begin
        drive.hs_gate = s_q.hs && !pin_s.cl_trip;
        drive.ls_gate = s_q.ls;
        drive.ss_force_low = (s_q.fsm == bpc_pkg::ST_OFF)
            || (s_q.fsm == bpc_pkg::ST_HICCUP);
        drive.ss_clamp_en = (s_q.clamp_cnt == bpc_pkg::CLAMP_EVENTS);
        drive.erramp_off = is_sec;
        drive.internal_comp = s_q.comp_int && !is_sec && !is_pri;
        drive.spread_en = spread;
        drive.pulse_skip = s_q.skip;
    end

    assign good_flag_sync_out = s_q.sync_out;
    assign good_flag_sync_oe = s_q.sync_oe;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign pready = 1'b1;

endmodule

// file: verification/bpc_chk.sv
// bpc_chk: concurrent checks on the ports of bpc_top.
// assumes pins are async, so each relation allows for the sync delay.
`timescale 1ns/1ps
module bpc_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire bpc_pkg::bpc_pins_t pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire bpc_pkg::bpc_drive_t drive,
    input wire logic good_flag_sync_out,
    input wire logic good_flag_sync_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // helper: clocks since the limit comparator was last high
    // ----------------------------------------------------------------
    logic [7:0] trip_age_q;
    logic [7:0] trip_age_d;

    // saturates so an idle limit never wraps back to young
    always_comb begin
        trip_age_d = pins.cl_trip ? 8'h00 : trip_age_q + {7'h00, trip_age_q != 8'hff};
    end

    // registered age
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trip_age_q <= 8'hff;
        end else begin
            trip_age_q <= trip_age_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    trip_cuts_a: assert property (pins.cl_trip [*3] |-> !drive.hs_gate)
        else $error("high-side gate on during current limit");
    clamp_cause_a: assert property ($rose(drive.ss_clamp_en) |-> trip_age_q < 8'hc8)
        else $error("clamp enabled without recent limit events");
    hiccup_off_a: assert property (drive.ss_force_low |-> !drive.hs_gate && !drive.ls_gate)
        else $error("gate driven while soft-start held low");
    sec_amp_a: assert property (drive.erramp_off |-> !drive.internal_comp && !good_flag_sync_oe)
        else $error("secondary with internal comp or sync out");
    off_clear_a: assert property (!pins.en [*6] |-> drive.ss_force_low && !drive.ss_clamp_en)
        else $error("state not cleared while disabled");
    en_cycle_a: assert property ($fell(pins.en) |-> ##[1:6] drive.ss_force_low)
        else $error("soft-start not pulled low after enable drop");
    sync_gate_a: assert property ($rose(good_flag_sync_out) |-> good_flag_sync_oe)
        else $error("sync pulse without primary output enable");
    apb_unmapped_a: assert property (psel && !penable && paddr > 8'h04 |=> pslverr)
        else $error("unmapped access without slave error");
endmodule

bind bpc_top bpc_chk u_chk (
    .clk(clk),
    .reset_n(reset_n),
    .pins(pins),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .pslverr(pslverr),
    .drive(drive),
    .good_flag_sync_out(good_flag_sync_out),
    .good_flag_sync_oe(good_flag_sync_oe)
);

// file: verification/bpc_peer.sv
// bpc_peer: the other converter of an interleaved pair.
// assumes only its sync clock or mode-strap level reaches this device.
`timescale 1ns/1ps
module bpc_peer (
    input wire logic run,
    input wire logic level,
    output logic sync_line
);
    logic link_clk = 1'b0;

    // peer primary sync clock, 320 ns, odd start so no phase tie to clk
    initial begin
        #13;
        forever begin
            #160;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end

    // stopped clock leaves the strapped level on the pin
    assign sync_line = run ? link_clk : level;
endmodule

// file: verification/tb_top.sv
// tb_top: directed bench for bpc_top over apb and its pins.
// assumes shortened soft-start and hiccup off-time parameters.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    bpc_pkg::bpc_pins_t pin_q;
    bpc_pkg::bpc_pins_t pins_in;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bpc_pkg::bpc_drive_t drive;
    logic sync_out;
    logic sync_oe;
    logic peer_run = 1'b0;
    logic peer_lvl = 1'b0;
    logic peer_line;
    logic prev_sync = 1'b0;
    logic [31:0] rdat;
    logic rerr;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int rises = 0;
    int mark;

    always #20 clk = ~clk;

    // mode pin belongs to the peer model, the rest to the bench
    always_comb begin
        pins_in = pin_q;
        pins_in.mode_sync_in = peer_line;
    end

    bpc_top #(.SS_CYCLES(50), .HICCUP_OFF(8)) uut (
        .clk(clk), .reset_n(reset_n), .pins(pins_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive(drive), .good_flag_sync_out(sync_out),
        .good_flag_sync_oe(sync_oe));
    bpc_peer peer (.run(peer_run), .level(peer_lvl), .sync_line(peer_line));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer, entered just after an edge; leaves one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic status();
        apb(1'b0, bpc_pkg::REG_STATUS, 32'h0);
    endtask

    task automatic enable_cfg(input logic [2:0] c);
        pin_q.en <= 1'b0;
        pin_q.config_code <= c;
        tick(8);
        pin_q.en <= 1'b1;
        tick(8);
    endtask

    // watchdog and sync pulse counter
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prev_sync <= sync_out;
        if (sync_out && !prev_sync) begin
            rises <= rises + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        pin_q = '0;
        pin_q.comp_strap = 1'b1;
        pin_q.pwm_on = 1'b1;
        pin_q.fb_tied_high = 1'b1;
        tick(10);
        check("drive in reset", drive, 32'h20);
        check("apb in reset", {prdata[27:0], pready, pslverr, sync_out, sync_oe}, 32'h8);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, bpc_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", rdat, 32'h3e);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped", {rdat[30:0], rerr}, 32'h1);
        apb(1'b1, bpc_pkg::REG_CTRL, 32'hffff0007);
        apb(1'b0, bpc_pkg::REG_CTRL, 32'h0);
        check("ctrl rw", rdat, 32'h7);
        // every strap code; later strap change must not stick
        for (int c = 0; c < 5; c++) begin
            enable_cfg(c[2:0]);
            pin_q.config_code <= (c == 4) ? 3'h0 : 3'h4;
            tick(8);
            status();
            check("cfg", rdat[4:0], {c[2:0], 2'h1});
            check("erramp", drive.erramp_off, c == 4);
            check("sec light", rdat[6], c == 4);
            check("spread", drive.spread_en, c == 1 || c == 3);
            check("sync oe", sync_oe, c == 2 || c == 3);
            check("int comp", drive.internal_comp, c < 2);
        end
        peer_run <= 1'b1;
        tick(4);
        status();
        check("not locked", rdat[7], 1'b0);
        tick(60);
        status();
        check("locked", rdat[7], 1'b1);
        peer_run <= 1'b0;
        tick(90);
        status();
        check("lock lost", rdat[7], 1'b0);
        enable_cfg(3'h2);
        tick(60);
        status();
        check("run", rdat[1:0], 2'h2);
        mark = rises;
        tick(80);
        check("sync rises", (rises - mark) inside {[9:11]}, 1'b1);
        peer_lvl <= 1'b1;
        pin_q.ton_short <= 1'b1;
        tick(90);
        status();
        check("light skip", rdat[8:6], 3'b101);
        mark = rises;
        tick(80);
        check("sync stopped", rises - mark, 0);
        peer_lvl <= 1'b0;
        pin_q.ton_short <= 1'b0;
        pin_q.cl_trip <= 1'b1;
        tick(40);
        status();
        check("unarmed", rdat[19:10], 10'h0);
        pin_q.fb_above <= 1'b1;
        tick(200);
        status();
        check("clamp armed", {rdat[19], rdat[9], rdat[18:10] != 0}, 3'b111);
        pin_q.cl_trip <= 1'b0;
        tick(60);
        status();
        check("clean clear", rdat[18:9], 10'h0);
        pin_q.cl_trip <= 1'b1;
        tick(4000);
        status();
        check("near terminal", {rdat[18:10] > 480, rdat[1:0]}, 3'b110);
        tick(120);
        status();
        check("restart", {rdat[18:10] < 40, rdat[1:0]}, 3'b110);
        pin_q.fb_above <= 1'b0;
        tick(3800);
        repeat (200) begin
            status();
            if (rdat[1:0] === 2'h3) break;
        end
        pin_q.cl_trip <= 1'b0;
        check("hiccup", {rdat[1:0], drive.hs_gate, drive.ls_gate, drive.ss_force_low}, 5'h19);
        tick(20);
        status();
        check("off time", rdat[1:0], 2'h3);
        tick(60);
        status();
        check("resoft", rdat[1:0], 2'h1);
        pin_q.comp_strap <= 1'b0;
        enable_cfg(3'h0);
        check("comp held", drive.internal_comp, 1'b1);
        reset_n <= 1'b0;
        tick(3);
        reset_n <= 1'b1;
        enable_cfg(3'h0);
        check("comp external", drive.internal_comp, 1'b0);
        give_verdict();
    end
endmodule
